// file: core/ims_baud.sv
`timescale 1ns/10ps
module ims_baud #(
  parameter int W = ims_pkg::BAUD_W
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rstn_i,
  input  wire logic         ld_i,
  input  wire logic [W-1:0] reload_i,
  output logic              tmo_o
);
  logic [W-1:0] cnt_q;
  logic         act_q;

  // Counts down to zero, then stops until the next load
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_q <= '0;
      act_q <= 1'b0;
    end
    else if (ld_i)
    begin
      cnt_q <= reload_i;
      act_q <= 1'b1;
    end
    else if (act_q)
    begin
      if (cnt_q == '0)
        act_q <= 1'b0;
      else
        cnt_q <= cnt_q - 1'b1;
    end
  end

  assign tmo_o = act_q && (cnt_q == '0);
endmodule

// file: core/ims_sync.sv
`timescale 1ns/10ps
module ims_sync #(
  parameter int W = 2
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  // Lines idle high, so both stages reset high
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta_q <= '1;
      q_o    <= '1;
    end
    else
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

// file: core/ims_top.sv
// How it works
// - Start with both lines high loads baud counter; drives data low at timeout
// - Data falling while clock high sets start-detected status bit
// - After start, reload; next timeout clears start request, data stays low
// - Lines low at start, or clock low early: collision, abort, idle
// - Buffer write during start is dropped and sets write collision
// - Sequence control low bits ignored until start or restart completes
// - Restart from idle pulls clock low, then releases data one period
// - Data high at timeout releases clock; both lines high one period
// - Data low one period with clock high, then restart clears itself
// - Restart edge sets start-detected; interrupt flag only after timeout
// - Restart request while busy has no effect
// - Restart collision: data low at clock rise, or clock drops early
// - Buffer write during restart is dropped and sets write collision
// - Buffer write sets buffer full and starts the baud counter
// - Each bit: data after clock fall, clock low then high one period
// - Eighth falling edge clears buffer full and releases data
// - Ninth bit data sampled as acknowledge status, low means acknowledged
// - After ninth clock set interrupt flag, stop counter, hold clock low
// - Write during transmit sets write collision; updates only within 2 Tcy
// - Receive request honoured only when idle
// - Receive: eight bits shifted in, buffer loaded, flags set, read clears
// - Byte completing while buffer full sets receive overflow
// - Buffer write during receive is dropped and sets write collision
// - Baud counter counts to zero and stops until reloaded
// - Released clock: counter waits until clock is sampled high
// - Any collision sets collision flag, releases lines, returns idle
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/10ps
module ims_top (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rstn_i,
  input  wire logic [2:0]               addr_i,
  input  wire logic [ims_pkg::DW-1:0]   wdata_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output logic      [ims_pkg::DW-1:0]   rdata_o,
  input  wire logic                     serial_clock_line_i,
  output logic                          serial_clock_line_o,
  output logic                          serial_clock_line_oe_o,
  input  wire logic                     serial_data_line_i,
  output logic                          serial_data_line_o,
  output logic                          serial_data_line_oe_o
);
  ims_pkg::ims_state_e         state_q;
  logic [1:0]                  lines_s;
  logic                        scl_s, sda_s, sda_p_q;
  logic                        tmo, coll, ld_q, rx_q;
  logic [3:0]                  bit_q;
  logic [ims_pkg::DW-1:0]      buf_q, shift_q;
  logic [ims_pkg::BAUD_W-1:0]  baud_reload_q;
  logic                        start_q, restart_q, rcv_q, ack_q;
  logic                        bf_q, sstart_q, pif_q, write_collision_flag_q, ov_q, cif_q;
  logic                        sda_nx_q;
  logic [2:0]                  wage_q;
  logic                        buf_wr, ctl_wr, flg_wr, tx_busy, buf_upd;
  logic [ims_pkg::DW-1:0]      flg_clr;

  ims_sync #(.W(2)) u_sync (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .d_i       ({serial_clock_line_i, serial_data_line_i}),
    .q_o       (lines_s)
  );
  assign scl_s = lines_s[1];
  assign sda_s = lines_s[0];

  ims_baud #(.W(ims_pkg::BAUD_W)) u_baud (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .ld_i      (ld_q),
    .reload_i  (baud_reload_q),
    .tmo_o     (tmo)
  );

  assign buf_wr  = wr_i && (addr_i == ims_pkg::A_BUF);
  assign ctl_wr  = wr_i && (addr_i == ims_pkg::A_CTL);
  assign flg_wr  = wr_i && (addr_i == ims_pkg::A_FLAG);
  assign flg_clr = flg_wr ? wdata_i : '0;
  assign tx_busy = !rx_q && (state_q inside {ims_pkg::S_BIT_LOW,
                   ims_pkg::S_BIT_REL, ims_pkg::S_BIT_HIGH});
  assign buf_upd = buf_wr && (state_q == ims_pkg::S_IDLE ||
                   (tx_busy && wage_q < 3'(ims_pkg::WRITE_COLLISION_FLAG_CLKS)));

  // Lines lost to another master during start or restart
  always_comb
  begin
    unique case (state_q)
      ims_pkg::S_IDLE:
        coll = ctl_wr && wdata_i[ims_pkg::CTL_START] &&
               !(scl_s && sda_s);
      ims_pkg::S_ST_WAIT:  coll = !scl_s || (tmo && !sda_s);
      ims_pkg::S_RS_SDA:   coll = tmo && !sda_s;
      ims_pkg::S_RS_REL:   coll = scl_s && !sda_s;
      ims_pkg::S_RS_HIGH:  coll = !scl_s || !sda_s;
      ims_pkg::S_RS_SDALO: coll = !scl_s;
      default:             coll = 1'b0;
    endcase
  end

  // Age of the last accepted buffer write
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      wage_q <= 3'h7;
    else if (buf_upd)
      wage_q <= 3'h0;
    else if (wage_q != 3'h7)
      wage_q <= wage_q + 3'h1;
  end

  // Start seen on the lines
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sda_p_q  <= 1'b1;
      sstart_q <= 1'b0;
    end
    else
    begin
      sda_p_q <= sda_s;
      if (sda_p_q && !sda_s && scl_s)
        sstart_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      baud_reload_q <= ims_pkg::BAUD_RST;
    else if (wr_i && addr_i == ims_pkg::A_BAUD)
      baud_reload_q <= wdata_i[ims_pkg::BAUD_W-1:0];
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_o <= '0;
    else if (rd_i)
    begin
      unique case (addr_i)
        ims_pkg::A_BUF:  rdata_o <= buf_q;
        ims_pkg::A_CTL:  rdata_o <= {1'b0, ack_q, 2'b00, rcv_q, 1'b0,
                                     restart_q, start_q};
        ims_pkg::A_STAT: rdata_o <= {4'h0, sstart_q, 2'b00, bf_q};
        ims_pkg::A_BAUD: rdata_o <= {1'b0, baud_reload_q};
        ims_pkg::A_FLAG: rdata_o <= {4'h0, cif_q, ov_q, write_collision_flag_q, pif_q};
        default:         rdata_o <= '0;
      endcase
    end
    else
      rdata_o <= '0;
  end

  assign serial_clock_line_o = 1'b0;
  assign serial_data_line_o  = 1'b0;

  // Sequencer, buffer and event flags
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_q <= ims_pkg::S_IDLE;
      serial_clock_line_oe_o <= 1'b0;
      serial_data_line_oe_o  <= 1'b0;
      ld_q <= 1'b0;  rx_q <= 1'b0;  bit_q <= 4'h0;
      buf_q <= '0;   shift_q <= '0;
      start_q <= 1'b0; restart_q <= 1'b0; rcv_q <= 1'b0; ack_q <= 1'b0;
      bf_q <= 1'b0; pif_q <= 1'b0; write_collision_flag_q <= 1'b0; ov_q <= 1'b0;
      cif_q <= 1'b0;
      sda_nx_q <= 1'b0;
    end
    else
    begin
      ld_q <= 1'b0;
      // Software clears first so a same-cycle set wins
      if (flg_clr[ims_pkg::FLG_PIF])  pif_q  <= 1'b0;
      if (flg_clr[ims_pkg::FLG_WRITE_COLLISION_FLAG]) write_collision_flag_q <= 1'b0;
      if (flg_clr[ims_pkg::FLG_OV])   ov_q   <= 1'b0;
      if (flg_clr[ims_pkg::FLG_CIF])  cif_q  <= 1'b0;
      if (rd_i && addr_i == ims_pkg::A_BUF && state_q == ims_pkg::S_IDLE)
        bf_q <= 1'b0;
      if (buf_wr && state_q != ims_pkg::S_IDLE)
        write_collision_flag_q <= 1'b1;
      if (buf_upd && tx_busy)
        buf_q <= wdata_i;
      if (coll)
      begin
        cif_q <= 1'b1;
        serial_clock_line_oe_o <= 1'b0;
        serial_data_line_oe_o  <= 1'b0;
        start_q <= 1'b0;
        restart_q <= 1'b0;
        bf_q <= 1'b0;
        state_q <= ims_pkg::S_IDLE;
      end
      else
      begin
        unique case (state_q)
          ims_pkg::S_IDLE:
            if (ctl_wr)
            begin
              if (wdata_i[ims_pkg::CTL_START])
              begin
                start_q <= 1'b1;
                ld_q <= 1'b1;
                state_q <= ims_pkg::S_ST_WAIT;
              end
              else if (wdata_i[ims_pkg::CTL_RESTART])
              begin
                restart_q <= 1'b1;
                serial_clock_line_oe_o <= 1'b1;
                state_q <= ims_pkg::S_RS_LOW;
              end
              else if (wdata_i[ims_pkg::CTL_RECV])
              begin
                rcv_q <= 1'b1; rx_q <= 1'b1; bit_q <= 4'h0;
                serial_clock_line_oe_o <= 1'b1;
                serial_data_line_oe_o  <= 1'b0;
                ld_q <= 1'b1;
                state_q <= ims_pkg::S_BIT_LOW;
              end
            end
            else if (buf_wr)
            begin
              buf_q <= wdata_i; shift_q <= wdata_i;
              bf_q <= 1'b1;
              rx_q <= 1'b0; bit_q <= 4'h0;
              serial_clock_line_oe_o <= 1'b1;
              sda_nx_q <= ~wdata_i[ims_pkg::DW-1];
              ld_q <= 1'b1;
              state_q <= ims_pkg::S_BIT_LOW;
            end
          ims_pkg::S_ST_WAIT:
            if (tmo)
            begin
              serial_data_line_oe_o <= 1'b1;
              ld_q <= 1'b1;
              state_q <= ims_pkg::S_ST_HOLD;
            end
          ims_pkg::S_ST_HOLD:
            if (tmo)
            begin
              start_q <= 1'b0;
              pif_q <= 1'b1;
              state_q <= ims_pkg::S_IDLE;
            end
          ims_pkg::S_RS_LOW:
            if (!scl_s)
            begin
              serial_data_line_oe_o <= 1'b0;
              ld_q <= 1'b1;
              state_q <= ims_pkg::S_RS_SDA;
            end
          ims_pkg::S_RS_SDA:
            if (tmo)
            begin
              serial_clock_line_oe_o <= 1'b0;
              state_q <= ims_pkg::S_RS_REL;
            end
          ims_pkg::S_RS_REL:
            if (scl_s)
            begin
              ld_q <= 1'b1;
              state_q <= ims_pkg::S_RS_HIGH;
            end
          ims_pkg::S_RS_HIGH:
            if (tmo)
            begin
              serial_data_line_oe_o <= 1'b1;
              ld_q <= 1'b1;
              state_q <= ims_pkg::S_RS_SDALO;
            end
          ims_pkg::S_RS_SDALO:
            if (tmo)
            begin
              restart_q <= 1'b0;
              pif_q <= 1'b1;
              state_q <= ims_pkg::S_IDLE;
            end
          ims_pkg::S_BIT_LOW:
          begin
            // Data moves a cycle after the clock falls, never with it
            if (!rx_q)
              serial_data_line_oe_o <= sda_nx_q;
            if (tmo)
            begin
              serial_clock_line_oe_o <= 1'b0;
              state_q <= ims_pkg::S_BIT_REL;
            end
          end
          ims_pkg::S_BIT_REL:
            if (scl_s)
            begin
              ld_q <= 1'b1;
              state_q <= ims_pkg::S_BIT_HIGH;
            end
          ims_pkg::S_BIT_HIGH:
            if (tmo)
            begin
              serial_clock_line_oe_o <= 1'b1;
              if (rx_q)
              begin
                shift_q <= {shift_q[ims_pkg::DW-2:0], sda_s};
                if (bit_q == ims_pkg::BIT_LAST_RX)
                begin
                  buf_q <= {shift_q[ims_pkg::DW-2:0], sda_s};
                  if (bf_q)
                    ov_q <= 1'b1;
                  bf_q <= 1'b1;
                  pif_q <= 1'b1;
                  rcv_q <= 1'b0;
                  state_q <= ims_pkg::S_IDLE;
                end
                else
                begin
                  bit_q <= bit_q + 4'h1;
                  ld_q <= 1'b1;
                  state_q <= ims_pkg::S_BIT_LOW;
                end
              end
              else if (bit_q == ims_pkg::BIT_ACK)
              begin
                ack_q <= sda_s;
                pif_q <= 1'b1;
                state_q <= ims_pkg::S_IDLE;
              end
              else
              begin
                if (bit_q == ims_pkg::BIT_DROP)
                begin
                  bf_q <= 1'b0;
                  sda_nx_q <= 1'b0;
                end
                else
                  sda_nx_q <= ~shift_q[ims_pkg::DW-2];
                shift_q <= {shift_q[ims_pkg::DW-2:0], 1'b0};
                bit_q <= bit_q + 4'h1;
                ld_q <= 1'b1;
                state_q <= ims_pkg::S_BIT_LOW;
              end
            end
          default:
            state_q <= ims_pkg::S_IDLE;
        endcase
      end
    end
  end

  property p_start_load;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    state_q == ims_pkg::S_IDLE && ctl_wr && wdata_i[ims_pkg::CTL_START]
    && scl_s && sda_s |=> ld_q && state_q == ims_pkg::S_ST_WAIT;
  endproperty
  a_start_load: assert property (p_start_load)
    else $error("start did not load baud counter");

  property p_start_seen;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    sda_p_q && !sda_s && scl_s |=> sstart_q;
  endproperty
  a_start_seen: assert property (p_start_seen)
    else $error("start condition not flagged");

  property p_start_end;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    state_q == ims_pkg::S_ST_HOLD && tmo |=> !start_q
    && serial_data_line_oe_o && state_q == ims_pkg::S_IDLE;
  endproperty
  a_start_end: assert property (p_start_end)
    else $error("start did not complete with data low");

  property p_coll;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    coll |=> cif_q && !serial_clock_line_oe_o && !serial_data_line_oe_o
    && state_q == ims_pkg::S_IDLE;
  endproperty
  a_coll: assert property (p_coll)
    else $error("collision did not idle the port");

  property p_write_collision_flag_seq;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    buf_wr && state_q inside {[ims_pkg::S_ST_WAIT:ims_pkg::S_RS_SDALO]}
    |=> write_collision_flag_q && $stable(buf_q);
  endproperty
  a_write_collision_flag_seq: assert property (p_write_collision_flag_seq)
    else $error("buffer write during sequence not refused");

  property p_ctl_lock;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    ctl_wr && state_q != ims_pkg::S_IDLE && !coll
    && (start_q || restart_q) |=> $stable(rcv_q);
  endproperty
  a_ctl_lock: assert property (p_ctl_lock)
    else $error("sequence control accepted while busy");

  property p_tx_go;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    buf_wr && state_q == ims_pkg::S_IDLE && !ctl_wr
    |=> bf_q && ld_q && serial_clock_line_oe_o
    ##1 state_q == ims_pkg::S_BIT_LOW;
  endproperty
  a_tx_go: assert property (p_tx_go)
    else $error("buffer write did not start transmit");

  property p_ack;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    state_q == ims_pkg::S_BIT_HIGH && !rx_q && bit_q == ims_pkg::BIT_ACK
    && tmo |=> ack_q == $past(sda_s) && pif_q && serial_clock_line_oe_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge not captured");

  property p_pif_hold;
    @(posedge ref_clk_i) disable iff (!rstn_i)
    pif_q && !(flg_wr && wdata_i[ims_pkg::FLG_PIF]) |=> pif_q;
  endproperty
  a_pif_hold: assert property (p_pif_hold)
    else $error("interrupt flag cleared by hardware");
endmodule

// file: include/ims_pkg.sv
package ims_pkg;
  // Register offsets on the plain register port
  localparam logic [2:0] A_BUF  = 3'h0;
  localparam logic [2:0] A_CTL  = 3'h1;
  localparam logic [2:0] A_STAT = 3'h2;
  localparam logic [2:0] A_BAUD = 3'h3;
  localparam logic [2:0] A_FLAG = 3'h4;
  // sequence_control fields
  localparam int CTL_START   = 0;
  localparam int CTL_RESTART = 1;
  localparam int CTL_RECV    = 3;
  localparam int CTL_ACKST   = 6;
  // port_status fields
  localparam int STAT_BF    = 0;
  localparam int STAT_START = 3;
  // Event flag fields, write one to clear
  localparam int FLG_PIF  = 0;
  localparam int FLG_WRITE_COLLISION_FLAG = 1;
  localparam int FLG_OV   = 2;
  localparam int FLG_CIF  = 3;
  localparam int DW     = 8;
  localparam int BAUD_W = 7;
  localparam logic [BAUD_W-1:0] BAUD_RST = 7'h00;
  // Counter steps twice per instruction cycle, once per clock
  localparam int TCY_CLKS  = 2;
  localparam int WRITE_COLLISION_FLAG_TCY  = 2;
  localparam int WRITE_COLLISION_FLAG_CLKS = WRITE_COLLISION_FLAG_TCY * TCY_CLKS;
  localparam logic [3:0] BIT_LAST_RX = 4'h7;
  localparam logic [3:0] BIT_DROP    = 4'h7;
  localparam logic [3:0] BIT_ACK     = 4'h8;
  typedef enum logic [3:0] {
    S_IDLE     = 4'h0,
    S_ST_WAIT  = 4'h1,
    S_ST_HOLD  = 4'h2,
    S_RS_LOW   = 4'h3,
    S_RS_SDA   = 4'h4,
    S_RS_REL   = 4'h5,
    S_RS_HIGH  = 4'h6,
    S_RS_SDALO = 4'h7,
    S_BIT_LOW  = 4'h8,
    S_BIT_REL  = 4'h9,
    S_BIT_HIGH = 4'ha
  } ims_state_e;
endpackage

// file: test/i2c_master_sequencer_bench.sv
`timescale 1ns/10ps
module i2c_master_sequencer_bench;
  logic       clk;
  logic       rstn;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       scl_oe;
  logic       sda_oe;
  logic       slv_scl;
  logic       slv_sda;
  logic       tb_scl;
  logic       tb_sda;
  logic       ack_en;
  logic       rd_mode;
  logic       stretch;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic [7:0] starts;
  logic [7:0] s0;
  logic [7:0] b0;
  logic       scl;
  logic       sda;
  int         n_fail;
  int         tests_run;

  // Open-drain wires with pull-ups
  assign scl = !(scl_oe | slv_scl | tb_scl);
  assign sda = !(sda_oe | slv_sda | tb_sda);

  ims_top u_dut (
    .ref_clk_i              (clk),
    .rstn_i                 (rstn),
    .addr_i                 (addr),
    .wdata_i                (wdata),
    .wr_i                   (wr),
    .rd_i                   (rd),
    .rdata_o                (rdata),
    .serial_clock_line_i    (scl),
    .serial_clock_line_o    (),
    .serial_clock_line_oe_o (scl_oe),
    .serial_data_line_i     (sda),
    .serial_data_line_o     (),
    .serial_data_line_oe_o  (sda_oe)
  );

  ims_slave_model u_slave (
    .scl_i      (scl),
    .sda_i      (sda),
    .ack_en_i   (ack_en),
    .rd_mode_i  (rd_mode),
    .stretch_i  (stretch),
    .tx_byte_i  (tx_byte),
    .scl_pull_o (slv_scl),
    .sda_pull_o (slv_sda),
    .rx_byte_o  (rx_byte),
    .starts_o   (starts)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic rd_chk(input string n, input logic [2:0] a,
                        input logic [7:0] e, input logic [7:0] m = 8'hff);
    logic [7:0] d;
    rd_reg(a, d);
    chk(n, e, d & m);
  endtask

  task automatic wait_bit(input logic [2:0] a, input int b, input logic v);
    logic [7:0] d;
    int         n = 0;
    rd_reg(a, d);
    while (d[b] !== v && n < 2000)
    begin
      rd_reg(a, d);
      n++;
    end
    chk("wait bit", {7'h00, v}, {7'h00, d[b]});
  endtask

  task automatic t_regs;
    rd_chk("baud rst", ims_pkg::A_BAUD, ims_pkg::BAUD_RST);
    rd_chk("flags rst", ims_pkg::A_FLAG, 8'h00);
    rd_chk("unmapped", 3'h7, 8'h00);
    wr_reg(ims_pkg::A_BAUD, 8'h06);
    rd_chk("baud", ims_pkg::A_BAUD, 8'h06);
    $display("t_regs done");
  endtask

  task automatic t_start_coll;
    @(posedge clk);
    tb_scl <= 1'b1;
    wr_reg(ims_pkg::A_CTL, 8'h01);
    wait_bit(ims_pkg::A_FLAG, ims_pkg::FLG_CIF, 1'b1);
    rd_chk("ctl idle", ims_pkg::A_CTL, 8'h00, 8'h1f);
    chk("sda oe", 8'h00, {7'h00, sda_oe});
    tb_scl <= 1'b0;
    wr_reg(ims_pkg::A_FLAG, 8'h0f);
    rd_chk("flags clr", ims_pkg::A_FLAG, 8'h00);
    $display("t_start_coll done");
  endtask

  task automatic t_start;
    rd_reg(ims_pkg::A_BUF, b0);
    s0 = starts;
    wr_reg(ims_pkg::A_CTL, 8'h01);
    wr_reg(ims_pkg::A_BUF, 8'h5a);
    wr_reg(ims_pkg::A_CTL, 8'h02);
    rd_chk("ctl busy", ims_pkg::A_CTL, 8'h01, 8'h1f);
    wait_bit(ims_pkg::A_CTL, ims_pkg::CTL_START, 1'b0);
    rd_chk("flags", ims_pkg::A_FLAG, 8'h03);
    rd_chk("status", ims_pkg::A_STAT, 8'h08, 8'h09);
    rd_chk("buf kept", ims_pkg::A_BUF, b0);
    chk("starts", s0 + 8'h01, starts);
    chk("lines", 8'h01, {6'h00, scl_oe, sda_oe});
    rd_chk("ctl done", ims_pkg::A_CTL, 8'h00, 8'h1f);
    rd_chk("flags kept", ims_pkg::A_FLAG, 8'h03);
    wr_reg(ims_pkg::A_FLAG, 8'h0f);
    $display("t_start done");
  endtask

  task automatic t_tx(input logic [7:0] v, input logic ak,
                      input logic st, input logic rw);
    ack_en  <= ak;
    stretch <= st;
    wr_reg(ims_pkg::A_BUF, v);
    if (rw)
    begin
      wr_reg(ims_pkg::A_BUF, 8'h3c);
      repeat (20) @(posedge clk);
      wr_reg(ims_pkg::A_BUF, 8'h77);
      wr_reg(ims_pkg::A_CTL, 8'h08);
    end
    rd_chk("bf set", ims_pkg::A_STAT, 8'h01, 8'h01);
    wait_bit(ims_pkg::A_FLAG, ims_pkg::FLG_PIF, 1'b1);
    chk("wire byte", v, rx_byte);
    rd_chk("ack st", ims_pkg::A_CTL, {1'b0, ~ak, 6'h00}, 8'h48);
    rd_chk("bf clr", ims_pkg::A_STAT, 8'h00, 8'h01);
    chk("lines", 8'h02, {6'h00, scl_oe, sda_oe});
    rd_chk("flags", ims_pkg::A_FLAG, rw ? 8'h03 : 8'h01);
    if (rw)
      rd_chk("buf", ims_pkg::A_BUF, 8'h3c);
    wr_reg(ims_pkg::A_FLAG, 8'h0f);
    stretch <= 1'b0;
    $display("t_tx done");
  endtask

  task automatic t_rx;
    logic [7:0] rxv [3] = '{8'h96, 8'h3b, 8'hc5};
    for (int i = 0; i < 3; i++)
    begin
      rd_mode <= 1'b0;
      tx_byte <= rxv[i];
      @(posedge clk);
      rd_mode <= 1'b1;
      wr_reg(ims_pkg::A_CTL, 8'h08);
      if (i == 0)
        wr_reg(ims_pkg::A_BUF, 8'h11);
      wait_bit(ims_pkg::A_FLAG, ims_pkg::FLG_PIF, 1'b1);
      rd_chk("rx flags", ims_pkg::A_FLAG,
             i == 0 ? 8'h03 : (i == 2 ? 8'h05 : 8'h01));
      rd_chk("rx bf", ims_pkg::A_STAT, 8'h01, 8'h01);
      rd_chk("rx ctl", ims_pkg::A_CTL, 8'h00, 8'h08);
      if (i != 1)
        rd_chk("rx byte", ims_pkg::A_BUF, rxv[i]);
      wr_reg(ims_pkg::A_FLAG, 8'h0f);
    end
    rd_chk("bf read", ims_pkg::A_STAT, 8'h00, 8'h01);
    rd_mode <= 1'b0;
    $display("t_rx done");
  endtask

  task automatic t_restart;
    s0 = starts;
    wr_reg(ims_pkg::A_CTL, 8'h02);
    wr_reg(ims_pkg::A_BUF, 8'h22);
    wait_bit(ims_pkg::A_CTL, ims_pkg::CTL_RESTART, 1'b0);
    rd_chk("flags", ims_pkg::A_FLAG, 8'h03);
    chk("starts", s0 + 8'h01, starts);
    chk("lines", 8'h01, {6'h00, scl_oe, sda_oe});
    rd_chk("buf kept", ims_pkg::A_BUF, 8'hc5);
    wr_reg(ims_pkg::A_FLAG, 8'h0f);
    @(posedge clk);
    tb_sda <= 1'b1;
    wr_reg(ims_pkg::A_CTL, 8'h02);
    wait_bit(ims_pkg::A_FLAG, ims_pkg::FLG_CIF, 1'b1);
    rd_chk("ctl idle", ims_pkg::A_CTL, 8'h00, 8'h02);
    chk("released", 8'h00, {6'h00, scl_oe, sda_oe});
    tb_sda <= 1'b0;
    $display("t_restart done");
  endtask

  task automatic give_verdict;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    rstn      = 1'b0;
    addr      = 3'h0;
    wdata     = 8'h00;
    wr        = 1'b0;
    rd        = 1'b0;
    tb_scl    = 1'b0;
    tb_sda    = 1'b0;
    ack_en    = 1'b0;
    rd_mode   = 1'b0;
    stretch   = 1'b0;
    tx_byte   = 8'h00;
    n_fail    = 0;
    tests_run = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_regs;
    t_start_coll;
    t_start;
    t_tx(8'ha5, 1'b1, 1'b0, 1'b1);
    t_tx(8'hc3, 1'b0, 1'b1, 1'b0);
    t_rx;
    t_restart;
    give_verdict;
  end

  // Run needs some ten thousand cycles at most
  initial
  begin
    #200000;
    n_fail++;
    $display("watchdog expired");
    give_verdict;
  end
endmodule

// file: test/ims_slave_model.sv
`timescale 1ns/10ps
module ims_slave_model (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       ack_en_i,
  input  wire logic       rd_mode_i,
  input  wire logic       stretch_i,
  input  wire logic [7:0] tx_byte_i,
  output logic            scl_pull_o,
  output logic            sda_pull_o,
  output logic [7:0]      rx_byte_o,
  output logic [7:0]      starts_o
);
  int   nbit  = 0;
  int   nfall = 0;
  logic ack_q = 1'b0;

  initial
  begin
    scl_pull_o = 1'b0;
    rx_byte_o  = 8'h00;
    starts_o   = 8'h00;
  end

  // Start or repeated start seen on the wire
  always @(negedge sda_i)
  begin
    if (scl_i)
    begin
      nbit     = 0;
      starts_o = starts_o + 8'h01;
    end
  end

  always @(posedge scl_i)
  begin
    if (!rd_mode_i && nbit < 8)
      rx_byte_o = {rx_byte_o[6:0], sda_i};
    nbit = nbit + 1;
  end

  always @(posedge rd_mode_i)
    nfall = 0;

  always @(negedge scl_i)
  begin
    ack_q = ack_en_i && !rd_mode_i && nbit == 8;
    if (nbit == 9)
      nbit = 0;
    nfall = nfall + 1;
  end

  // Holds the clock low after each fall to stretch the low time
  always @(negedge scl_i)
  begin
    if (stretch_i)
    begin
      scl_pull_o = 1'b1;
      #100;
      scl_pull_o = 1'b0;
    end
  end

  // Sends MSB first, next bit after each clock fall
  assign sda_pull_o = ack_q
                    | (rd_mode_i && nfall < 8
                       && !tx_byte_i[3'(7 - nfall)]);
endmodule
